/* design/serirq_pkg.sv */
// Shared constants and types for both ends of the serial interrupt line
package serirq_pkg;

    // Frame slots in one cycle, and the width of a frame counter
    localparam int unsigned FRAME_SLOTS = 32;
    localparam int unsigned FRAME_W = 6;

    // Fixed frame positions (1-based frame numbers)
    localparam logic [5:0] FRAME_IRQ0 = 6'h01;
    localparam logic [5:0] FRAME_IRQ1 = 6'h02;
    localparam logic [5:0] FRAME_SYSTEM_MANAGEMENT_INTERRUPT = 6'h03;
    localparam logic [5:0] FRAME_IOCHCK = 6'h11;
    localparam logic [5:0] FRAME_INTA = 6'h12;
    localparam logic [5:0] FRAME_INTB = 6'h13;
    localparam logic [5:0] FRAME_INTC = 6'h14;
    localparam logic [5:0] FRAME_INTD = 6'h15;
    localparam logic [5:0] FRAME_LAST_ASSIGNED = 6'h15;

    // Start pulse limits in clocks, total low time
    localparam int unsigned START_MIN_CLKS = 4;
    localparam int unsigned START_MAX_CLKS = 8;
    // Host share of a quiet-mode start pulse
    localparam int unsigned QUIET_EXTRA_MIN = 3;
    localparam int unsigned QUIET_EXTRA_MAX = 7;

    // Stop pulse widths; two selects quiet, three continuous
    localparam logic [1:0] STOP_QUIET_CLKS = 2'h2;
    localparam logic [1:0] STOP_CONT_CLKS = 2'h3;
    localparam logic [1:0] STOP_LOW_SAT = 2'h3;

    // Sample slot of frame k lies 3k-1 clocks after the first high clock
    localparam int unsigned FRAME_CLKS = 3;
    localparam int unsigned FIRST_SAMPLE_OFFSET = 2;

    // Mode after reset: continuous
    localparam logic QUIET_RESET = 1'b0;

    // Phases of one interrupt/data frame
    typedef enum logic [1:0] {
        PH_SAMPLE,
        PH_RECOVER,
        PH_TURN
    } phase_t;

    // Peripheral sequencer states
    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_START,
        DEV_FRAMES,
        DEV_WAIT_STOP,
        DEV_STOP
    } dev_state_t;

    // Host sequencer states
    typedef enum logic [2:0] {
        HOST_IDLE,
        HOST_START,
        HOST_HIGH,
        HOST_FRAMES,
        HOST_STOP,
        HOST_STOP_HIGH,
        HOST_TURN
    } host_state_t;

endpackage : serirq_pkg

/* design/serirq_if.sv */
// Shared open-drain serial interrupt wire joining peripheral and host
`timescale 1ns/1ps
`default_nettype none
interface serirq_if;
    logic dev_out;
    logic dev_oe;
    logic host_out;
    logic host_oe;
    logic line;

    // Pulled high; any enabled driver with a low value pulls it low
    assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));

    modport device (input line, output dev_out, output dev_oe);
    modport host (input line, output host_out, output host_oe);
endinterface : serirq_if
`default_nettype wire

/* design/serirq_device.sv */
// Peripheral end of the serial interrupt line
`timescale 1ns/1ps
`default_nettype none
module serirq_device #(
    parameter logic [31:0] OWNED_MASK = 32'h0000_0004
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [31:0] req,
    output logic quiet_mode,
    output logic [31:0] reported,
    serirq_if.device link
);

    // Device state; drive bits are registered so the wire comes from flip-flops
    typedef struct packed {
        serirq_pkg::dev_state_t state;
        serirq_pkg::phase_t phase;
        logic [5:0] frame;
        logic [1:0] low_cnt;
        logic quiet;
        logic line_prev;
        logic drv_oe;
        logic drv_out;
        logic [31:0] reported;
    } dev_regs_t;

    // Reset image: continuous, idle, wire released, nothing reported
    localparam dev_regs_t DEV_RESET = '{
        state: serirq_pkg::DEV_IDLE,
        phase: serirq_pkg::PH_TURN,
        frame: 6'h00,
        low_cnt: 2'h0,
        quiet: serirq_pkg::QUIET_RESET,
        line_prev: 1'b1,
        drv_oe: 1'b0,
        drv_out: 1'b1,
        reported: 32'h0000_0000
    };

    // Slot count at which the frame run is over
    localparam logic [5:0] LAST_SLOT = 6'(serirq_pkg::FRAME_SLOTS);

    // Whole state in one register, so the clock enable freezes it at once
    dev_regs_t s_reg;
    dev_regs_t s_next;
    logic pending;
    logic [31:0] changed;
    logic [4:0] cur_idx;
    logic [4:0] next_idx;

    // Whether this peripheral answers in a given slot
    function automatic logic owns(input logic [4:0] idx);
        owns = OWNED_MASK[idx];
    endfunction : owns

    // Short stop picks quiet; any other width falls back to continuous
    function automatic logic stop_is_quiet(input logic [1:0] width);
        stop_is_quiet = (width == serirq_pkg::STOP_QUIET_CLKS);
    endfunction : stop_is_quiet

    // Saturating stop count; a wire held low must not wrap back to quiet
    function automatic logic [1:0] stop_count(input logic [1:0] width);
        if (width == serirq_pkg::STOP_LOW_SAT) begin
            stop_count = width;
        end else begin
            stop_count = width + 2'h1;
        end
    endfunction : stop_count

    // One change flag per slot; unowned slots never ask for a start
    generate
        for (genvar g = 0; g < 32; g++) begin : g_slot
            assign changed[g] = OWNED_MASK[g] & (req[g] ^ s_reg.reported[g]);
        end
    endgenerate

    // Any owned source whose level differs from what was last sent
    assign pending = |changed;
    // Slot of the frame in progress, and of the one about to sample
    assign cur_idx = 5'(s_reg.frame - 6'h01);
    assign next_idx = s_reg.frame[4:0];

    // Sequencer; the line comes from same-clock logic, so no synchroniser
    always_comb begin
        // Hold by default; the wire stays released unless a slot or a quiet start drives it
        s_next = s_reg;
        s_next.line_prev = link.line;
        s_next.drv_oe = 1'b0; // Released unless a slot or the quiet start below drives
        s_next.drv_out = 1'b1;
        case (s_reg.state)
            serirq_pkg::DEV_IDLE: begin
                // Quiet start waits a settled high clock, so it never cuts a stop short
                if (!link.line) begin
                    // Someone else began a start pulse
                    s_next.state = serirq_pkg::DEV_START;
                end else if (s_reg.quiet && s_reg.line_prev && pending) begin
                    // One-clock low, then the host takes over
                    s_next.state = serirq_pkg::DEV_START;
                    s_next.drv_oe = 1'b1;
                    s_next.drv_out = 1'b0;
                end
            end
            serirq_pkg::DEV_START: begin
                // Rising edge ends the start pulse; frames count from here
                if (link.line) begin
                    s_next.state = serirq_pkg::DEV_FRAMES;
                    s_next.phase = serirq_pkg::PH_TURN;
                    s_next.frame = 6'h00;
                end
            end
            serirq_pkg::DEV_FRAMES: begin
                // Phase walks sample, recovery, turn-around in each frame
                case (s_reg.phase)
                    serirq_pkg::PH_TURN: begin
                        if (s_reg.frame == LAST_SLOT) begin
                            // Every slot counted; only the stop can follow
                            s_next.state = serirq_pkg::DEV_WAIT_STOP;
                        end else begin
                            // Next slot is a sample phase
                            s_next.phase = serirq_pkg::PH_SAMPLE;
                            s_next.frame = s_reg.frame + 6'h01;
                            // Owned slot: low when active, released when not
                            if (owns(next_idx)) begin
                                s_next.drv_oe = req[next_idx];
                                s_next.drv_out = 1'b0;
                                s_next.reported[next_idx] = req[next_idx];
                            end
                        end
                    end
                    serirq_pkg::PH_SAMPLE: begin
                        s_next.phase = serirq_pkg::PH_RECOVER;
                        if (owns(cur_idx)) begin
                            // Recovery drives high to speed the rise
                            s_next.drv_oe = 1'b1;
                            s_next.drv_out = 1'b1;
                        end
                    end
                    default: begin
                        if (!link.line) begin
                            // Low through a recovery clock can only be the stop
                            s_next.state = serirq_pkg::DEV_STOP;
                            s_next.low_cnt = serirq_pkg::STOP_QUIET_CLKS;
                        end else begin
                            s_next.phase = serirq_pkg::PH_TURN; // Turn-around left released
                        end
                    end
                endcase
            end
            serirq_pkg::DEV_WAIT_STOP: begin
                // All slots done; idle clocks may pass before the stop
                if (!link.line) begin
                    s_next.state = serirq_pkg::DEV_STOP;
                    s_next.low_cnt = 2'h1;
                end
            end
            default: begin
                if (!link.line) begin
                    // Still low: one more stop clock
                    s_next.low_cnt = stop_count(s_reg.low_cnt);
                end else begin
                    // Stop width picks the next cycle's mode
                    s_next.quiet = stop_is_quiet(s_reg.low_cnt);
                    s_next.state = serirq_pkg::DEV_IDLE;
                end
            end
        endcase
    end

    // Reset wins over the clock enable; comes up continuous and idle
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= DEV_RESET;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign link.dev_oe = s_reg.drv_oe;
    assign link.dev_out = s_reg.drv_out;
    assign quiet_mode = s_reg.quiet;
    assign reported = s_reg.reported;

endmodule : serirq_device
`default_nettype wire

/* design/serirq_host.sv */
// Host controller end of the serial interrupt line
`timescale 1ns/1ps
`default_nettype none
module serirq_host #(
    parameter int unsigned START_CLKS = 4,
    parameter int unsigned QUIET_EXTRA = 3,
    parameter int unsigned FRAME_COUNT = 21
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic start_req,
    input wire logic stop_quiet,
    output logic [31:0] irq_state,
    output logic cycle_done,
    output logic quiet_mode,
    serirq_if.host link
);

    typedef struct packed {
        serirq_pkg::host_state_t state;
        serirq_pkg::phase_t phase;
        logic [5:0] frame;
        logic [2:0] cnt;
        logic quiet;
        logic stop_quiet;
        logic drv_oe;
        logic drv_out;
        logic done;
        logic [31:0] irq_state;
    } host_regs_t;

    localparam host_regs_t HOST_RESET = '{
        state: serirq_pkg::HOST_IDLE,
        phase: serirq_pkg::PH_TURN,
        frame: 6'h00,
        cnt: 3'h0,
        quiet: serirq_pkg::QUIET_RESET,
        stop_quiet: 1'b0,
        drv_oe: 1'b0,
        drv_out: 1'b1,
        done: 1'b0,
        irq_state: 32'h0000_0000
    };

    host_regs_t s_reg;
    host_regs_t s_next;
    logic [4:0] cur_idx;

    assign cur_idx = 5'(s_reg.frame - 6'h01);

    // Cycle sequencer; outputs registered, so each drive shows one clock later
    always_comb begin
        s_next = s_reg;
        s_next.drv_oe = 1'b0;
        s_next.drv_out = 1'b1;
        s_next.done = 1'b0;
        case (s_reg.state)
            serirq_pkg::HOST_IDLE: begin
                if (s_reg.quiet && !link.line) begin
                    // Peripheral began; hold low a further few clocks
                    s_next.state = serirq_pkg::HOST_START;
                    s_next.drv_oe = 1'b1;
                    s_next.drv_out = 1'b0;
                    s_next.cnt = 3'(QUIET_EXTRA - 1);
                end else if (start_req) begin
                    // Host-begun start pulse
                    s_next.state = serirq_pkg::HOST_START;
                    s_next.drv_oe = 1'b1;
                    s_next.drv_out = 1'b0;
                    s_next.cnt = 3'(START_CLKS - 1);
                end
            end
            serirq_pkg::HOST_START: begin
                s_next.drv_oe = 1'b1;
                if (s_reg.cnt == 3'h0) begin
                    s_next.state = serirq_pkg::HOST_HIGH; // One high clock, then release
                end else begin
                    s_next.drv_out = 1'b0;
                    s_next.cnt = s_reg.cnt - 3'h1;
                end
            end
            serirq_pkg::HOST_HIGH: begin
                s_next.state = serirq_pkg::HOST_FRAMES;
                s_next.phase = serirq_pkg::PH_TURN;
                s_next.frame = 6'h00;
            end
            serirq_pkg::HOST_FRAMES: begin
                case (s_reg.phase)
                    serirq_pkg::PH_TURN: begin
                        if (s_reg.frame == 6'(FRAME_COUNT)) begin
                            // Stop width from the caller; pick continuous before reconfiguring
                            s_next.state = serirq_pkg::HOST_STOP;
                            s_next.stop_quiet = stop_quiet;
                            s_next.drv_oe = 1'b1;
                            s_next.drv_out = 1'b0;
                            s_next.cnt = stop_quiet ? 3'(serirq_pkg::STOP_QUIET_CLKS - 2'h1)
                                : 3'(serirq_pkg::STOP_CONT_CLKS - 2'h1);
                        end else begin
                            s_next.phase = serirq_pkg::PH_SAMPLE;
                            s_next.frame = s_reg.frame + 6'h01;
                        end
                    end
                    serirq_pkg::PH_SAMPLE: begin
                        // Low in a sample clock means that source is active
                        s_next.irq_state[cur_idx] = ~link.line;
                        s_next.phase = serirq_pkg::PH_RECOVER;
                    end
                    default: begin
                        s_next.phase = serirq_pkg::PH_TURN;
                    end
                endcase
            end
            serirq_pkg::HOST_STOP: begin
                s_next.drv_oe = 1'b1;
                if (s_reg.cnt == 3'h0) begin
                    s_next.state = serirq_pkg::HOST_STOP_HIGH;
                    s_next.quiet = s_reg.stop_quiet;
                end else begin
                    s_next.drv_out = 1'b0;
                    s_next.cnt = s_reg.cnt - 3'h1;
                end
            end
            serirq_pkg::HOST_STOP_HIGH: begin
                s_next.state = serirq_pkg::HOST_TURN;
            end
            default: begin
                s_next.state = serirq_pkg::HOST_IDLE; // Next start may follow at once
                s_next.done = 1'b1;
            end
        endcase
    end

    // Reset wins over the clock enable; continuous mode after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= HOST_RESET;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign link.host_oe = s_reg.drv_oe;
    assign link.host_out = s_reg.drv_out;
    assign irq_state = s_reg.irq_state;
    assign cycle_done = s_reg.done;
    assign quiet_mode = s_reg.quiet;

endmodule : serirq_host
`default_nettype wire

/* testbench/serirq_link_sva.sv */
// Timing checks on the shared serial interrupt wire between both ends
`timescale 1ns/1ps
`default_nettype none
module serirq_link_sva #(
    parameter int unsigned FRAME_COUNT = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic line,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic host_out,
    input wire logic host_oe
);
    localparam int unsigned STOP_AT = 3 * FRAME_COUNT + 2;
    logic [3:0] low_run_reg;
    logic [5:0] since_reg;
    logic quiet_reg;
    logic dev_low;
    logic busy;
    logic start_end;
    logic stop_end;

    // A nonzero run while high marks the clock just after a low pulse
    assign dev_low = dev_oe & ~dev_out;
    assign busy = (since_reg != 6'h00) && (since_reg < 6'(STOP_AT));
    assign start_end = line && (low_run_reg > 4'h3);
    assign stop_end = line && (low_run_reg != 4'h0) && (low_run_reg < 4'h4) && (since_reg >= 6'(STOP_AT))
        && (since_reg < 6'(STOP_AT + 4));

    // Low-run length, position after start, mode seen on the wire
    always_ff @(posedge clk) begin
        if (srst) begin
            low_run_reg <= 4'h0;
            since_reg <= 6'h3f;
            quiet_reg <= 1'b0;
        end else begin
            low_run_reg <= line ? 4'h0 : ((low_run_reg == 4'hf) ? 4'hf : low_run_reg + 4'h1);
            if (start_end)
                since_reg <= 6'h01;
            else if (since_reg != 6'h3f)
                since_reg <= since_reg + 6'h01;
            if (stop_end)
                quiet_reg <= (low_run_reg == 4'h2);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_NO_CONTENTION: assert property (!(dev_oe && host_oe && (dev_out != host_out)))
        else $error("both ends drive opposite levels");
    AST_RESET_IDLE: assert property ($fell(srst) |-> line && !dev_oe && !host_oe)
        else $error("line not idle after reset");
    AST_START_WIDTH: assert property (start_end |-> low_run_reg == 4'h4)
        else $error("start pulse width wrong");
    AST_HOST_HIGH: assert property (start_end |-> host_oe && host_out ##1 !host_oe)
        else $error("host high clock after start missing");
    AST_QUIET_HANDOFF: assert property (dev_low && !busy |=> host_oe && !host_out && !dev_oe)
        else $error("host did not take over quiet start");
    AST_QUIET_ONLY: assert property (dev_low && !busy |-> quiet_reg && $past(line))
        else $error("device start outside quiet idle");
    AST_DEV_ONE_LOW: assert property (dev_low |=> !dev_low)
        else $error("device low longer than one clock");
    AST_RECOVERY: assert property (dev_low && busy |=> dev_oe && dev_out ##1 !dev_oe)
        else $error("recovery or turn-around wrong");
    AST_SLOTS: assert property (dev_oe && busy |-> since_reg inside {6'h02, 6'h03, 6'h08, 6'h09})
        else $error("device drives outside its frames");
    AST_STOP_START: assert property (since_reg == 6'(STOP_AT) |-> host_oe && !host_out)
        else $error("stop not begun after last frame");
    AST_STOP_WIDTH: assert property (stop_end |-> low_run_reg inside {4'h2, 4'h3})
        else $error("stop pulse width wrong");

    // Main scenarios reached
    cover property (dev_low && !busy);
    cover property (stop_end && low_run_reg == 4'h2);
    cover property (stop_end && low_run_reg == 4'h3);
endmodule : serirq_link_sva
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench joining both ends of the serial interrupt line
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [31:0] req;
        logic use_start;
        logic sq;
        logic [31:0] irq;
    } row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [31:0] req = 32'h0;
    logic start_req = 1'b0;
    logic stop_quiet = 1'b0;
    logic dev_quiet;
    logic host_quiet;
    logic [31:0] reported;
    logic [31:0] irq_state;
    logic cycle_done;
    logic [3:0] start_w = 4'h0;
    logic [3:0] stop_w = 4'h0;
    int low_cnt = 0;
    int lows = 0;
    int snap = 0;
    int cycles = 0;
    int failures = 0;
    int comparisons = 0;
    // Frames 1 and 3 owned; row 4 asks an unowned frame
    row_t rows [5] = '{'{32'h1, 1'b1, 1'b0, 32'h1}, '{32'h5, 1'b1, 1'b1, 32'h5}, '{32'h4, 1'b0, 1'b1, 32'h4},
        '{32'h0, 1'b0, 1'b0, 32'h0}, '{32'h2, 1'b1, 1'b0, 32'h0}};

    serirq_if serirq_if_inst ();
    serirq_device #(.OWNED_MASK(32'h0000_0005)) serirq_device_inst (.clk(clk), .srst(srst), .ce(ce), .req(req),
        .quiet_mode(dev_quiet), .reported(reported), .link(serirq_if_inst.device));
    serirq_host #(.START_CLKS(4), .QUIET_EXTRA(3), .FRAME_COUNT(3)) serirq_host_inst (.clk(clk), .srst(srst),
        .ce(ce), .start_req(start_req), .stop_quiet(stop_quiet), .irq_state(irq_state), .cycle_done(cycle_done),
        .quiet_mode(host_quiet), .link(serirq_if_inst.host));
    serirq_link_sva #(.FRAME_COUNT(3)) checker_inst (.clk(clk), .srst(srst), .line(serirq_if_inst.line),
        .dev_out(serirq_if_inst.dev_out), .dev_oe(serirq_if_inst.dev_oe), .host_out(serirq_if_inst.host_out),
        .host_oe(serirq_if_inst.host_oe));

    always #10 clk = ~clk;

    // Wire monitor; long lows are starts, two or three are stops
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (serirq_if_inst.line === 1'b0) begin
            low_cnt <= low_cnt + 1;
            lows <= lows + 1;
        end else begin
            if (low_cnt > 3)
                start_w <= 4'(low_cnt);
            else if (low_cnt > 1)
                stop_w <= 4'(low_cnt);
            low_cnt <= 0;
        end
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // Bounded wait; a missing cycle shows as a failed check
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cycle_done !== 1'b1 && n < 200);
        check("cycle_done", {31'h0, cycle_done}, 32'h1);
    endtask : wait_done

    // One whole cycle, host or device started, then results
    task automatic run_row(input row_t r);
        @(posedge clk);
        req <= r.req;
        stop_quiet <= r.sq;
        start_req <= r.use_start;
        @(posedge clk);
        start_req <= 1'b0;
        wait_done();
        check("irq_state", irq_state, r.irq);
        check("reported", reported, r.req & 32'h5);
        check("host_quiet", {31'h0, host_quiet}, {31'h0, r.sq});
        check("dev_quiet", {31'h0, dev_quiet}, {31'h0, r.sq});
        check("start_w", {28'h0, start_w}, 32'h4);
        check("stop_w", {28'h0, stop_w}, r.sq ? 32'h2 : 32'h3);
    endtask : run_row

    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        #1;
        check("line", {31'h0, serirq_if_inst.line}, 32'h1);
        check("host_quiet", {31'h0, host_quiet}, 32'h0);
        check("irq_state", irq_state, 32'h0);
        foreach (rows[i]) run_row(rows[i]);
        // Continuous mode: a pending change must not start a cycle
        @(posedge clk);
        req <= 32'h1;
        snap = lows;
        repeat (40) @(posedge clk);
        #1;
        check("dev_start", 32'(lows - snap), 32'h0);
        run_row(row_t'{32'h1, 1'b1, 1'b1, 32'h1});
        // Reset in mid-cycle from quiet mode
        @(posedge clk);
        start_req <= 1'b1;
        @(posedge clk);
        start_req <= 1'b0;
        repeat (8) @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        check("line", {31'h0, serirq_if_inst.line}, 32'h1);
        check("host_quiet", {31'h0, host_quiet}, 32'h0);
        check("dev_quiet", {31'h0, dev_quiet}, 32'h0);
        check("reported", reported, 32'h0);
        run_row(row_t'{32'h1, 1'b1, 1'b0, 32'h1});
        // Clock enable low freezes both ends; a held request waits for it
        @(posedge clk);
        ce <= 1'b0;
        start_req <= 1'b1;
        snap = lows;
        repeat (10) @(posedge clk);
        #1;
        check("ce_frozen", 32'(lows - snap), 32'h0);
        check("ce_done", {31'h0, cycle_done}, 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        start_req <= 1'b0;
        wait_done();
        check("irq_state", irq_state, 32'h1);
        final_report();
    end
endmodule : testbench
`default_nettype wire
